// File: design/sbwm_write_mask.sv
// burst write port with per-lane write masking and read-back path
// Operation
// - write starts on true edge, port select low
// - all selects low write whole word
// - select0 only writes low lane
// - x8/x18: select1 only writes high lane
// - all selects high store nothing
// - x9: one select gates nine bits
// - x36: all four low write 36 bits
// - x36: each select gates its nine-bit lane
// - x36: all high leave word unchanged
// - selects sampled per word independently
// - second word goes to address plus one
// - data registered on both input edges
// - read data launched on output reference edges
// - power up deselected, outputs off
`timescale 1ns/1ps
`include "sbwm_defines.svh"
module sbwm_write_mask (
    input  wire logic                      mclk,
    input  wire logic                      rstn,
    input  wire logic [1:0]                width_strap,
    input  wire logic                      in_edge_ref_true,
    input  wire logic                      in_edge_ref_comp,
    input  wire logic                      output_timing_true,
    input  wire logic                      output_timing_comp,
    input  wire logic                      write_port_sel_n,
    input  wire logic                      read_port_sel_n,
    input  wire logic [`SBWM_SELW-1:0]     byte_lane_write_select_n,
    input  wire logic [`SBWM_DW-1:0]       write_input_bus,
    input  wire logic [`SBWM_AW-1:0]       write_addr,
    input  wire logic [`SBWM_AW-1:0]       read_addr,
    output logic [`SBWM_DW-1:0]            read_output_bus,
    output logic                           read_output_oe,
    output logic                           write_stall
);
    import sbwm_pkg::*;

    // all pins cross into mclk through two flops
    logic [`SBWM_PIN_W-1:0] pin_meta_r;
    logic [`SBWM_PIN_W-1:0] pin_sync_r;
    wire  [`SBWM_PIN_W-1:0] pin_raw;
    // clocks idle high, as parked, so release shows no false edge
    localparam logic [`SBWM_PIN_W-1:0] PIN_IDLE =
        {4'hF, 2'h3, 4'hF, 46'h0};

    assign pin_raw = {in_edge_ref_true, in_edge_ref_comp,
                      output_timing_true, output_timing_comp,
                      write_port_sel_n, read_port_sel_n,
                      byte_lane_write_select_n, write_input_bus,
                      write_addr, read_addr, width_strap};

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pin_meta_r <= PIN_IDLE;
            pin_sync_r <= PIN_IDLE;
        end else begin
            pin_meta_r <= pin_raw;
            pin_sync_r <= pin_meta_r;
        end
    end

    wire                  s_kt;
    wire                  s_kc;
    wire                  s_ct;
    wire                  s_cc;
    wire                  s_wps_n;
    wire                  s_rps_n;
    wire [`SBWM_SELW-1:0] s_sel_n;
    wire [`SBWM_DW-1:0]   s_data;
    wire [`SBWM_AW-1:0]   s_waddr;
    wire [`SBWM_AW-1:0]   s_raddr;
    wire [1:0]            s_strap;

    assign {s_kt, s_kc, s_ct, s_cc, s_wps_n, s_rps_n, s_sel_n,
            s_data, s_waddr, s_raddr, s_strap} = pin_sync_r;

    // edge detection works on the synchronised copies only
    logic [3:0] clk_prev_r;
    wire        kt_rise;
    wire        kc_rise;
    wire        ct_rise;
    wire        cc_rise;

    always_ff @(posedge mclk) begin
        if (!rstn) clk_prev_r <= 4'hF;
        else       clk_prev_r <= {s_kt, s_kc, s_ct, s_cc};
    end

    assign kt_rise = s_kt && !clk_prev_r[3];
    assign kc_rise = s_kc && !clk_prev_r[2];
    assign ct_rise = s_ct && !clk_prev_r[1];
    assign cc_rise = s_cc && !clk_prev_r[0];

    // straps caught once the synchroniser holds real pin values
    logic [1:0]  strap_cnt_r;
    logic        single_clk_r;
    sbwm_width_t mode_r;
    wire         strap_take;

    assign strap_take = (strap_cnt_r == `SBWM_STRAP_WAIT);

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            strap_cnt_r  <= 2'h0;
            single_clk_r <= 1'b0;
            mode_r       <= SBWM_X36;
        end else if (strap_cnt_r != 2'h3) begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
            if (strap_take) begin
                single_clk_r <= s_ct && s_cc;
                mode_r       <= sbwm_width_t'(s_strap);
            end
        end
    end

    // output reference: input pair in single clock mode
    wire oref_t_rise;
    wire oref_c_rise;

    assign oref_t_rise = single_clk_r ? kt_rise : ct_rise;
    assign oref_c_rise = single_clk_r ? kc_rise : cc_rise;

    // write burst capture
    sbwm_wstate_t         w_state_r;
    logic [`SBWM_DW-1:0]  word0_r;
    logic [`SBWM_SELW-1:0] sel0_r;
    sbwm_entry_t          pend0_r;
    sbwm_entry_t          pend1_r;
    logic                 pend0_v_r;
    logic                 pend1_v_r;
    wire                  wr_start;
    wire                  wr_second;
    wire                  pend_busy;

    assign wr_start  = (w_state_r == W_IDLE) && kt_rise && !s_wps_n;
    assign wr_second = (w_state_r == W_SECOND) && kc_rise;
    assign pend_busy = pend0_v_r || pend1_v_r;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            w_state_r <= W_IDLE;
        end else begin
            case (w_state_r)
                W_IDLE:   if (wr_start) w_state_r <= W_SECOND;
                W_SECOND: if (wr_second) w_state_r <= W_IDLE;
                default:  w_state_r <= W_IDLE;
            endcase
        end
    end

    // first word and its selects held until the address arrives
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            word0_r <= '0;
            sel0_r  <= '1;
        end else if (wr_start) begin
            word0_r <= s_data;
            sel0_r  <= s_sel_n;
        end
    end

    // fifo source side: two entries per burst, in order
    sbwm_stream_if wr_in ();
    sbwm_stream_if wr_out ();

    assign wr_in.valid = pend_busy;
    assign wr_in.entry = pend0_v_r ? pend0_r : pend1_r;

    // a burst finishing while the previous pair still waits is lost
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pend0_v_r <= 1'b0;
            pend1_v_r <= 1'b0;
            pend0_r   <= '0;
            pend1_r   <= '0;
        end else if (wr_second && !pend_busy) begin
            pend0_v_r     <= 1'b1;
            pend1_v_r     <= 1'b1;
            pend0_r.addr  <= s_waddr;
            pend0_r.data  <= word0_r;
            pend0_r.sel_n <= sel0_r;
            pend1_r.addr  <= s_waddr + `SBWM_AW'(1);
            pend1_r.data  <= s_data;
            pend1_r.sel_n <= s_sel_n;
        end else if (wr_in.ready) begin
            if (pend0_v_r)      pend0_v_r <= 1'b0;
            else if (pend1_v_r) pend1_v_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) write_stall <= 1'b0;
        else       write_stall <= pend_busy && !wr_in.ready;
    end

    sbwm_fifo #(
        .WIDTH ($bits(sbwm_entry_t)),
        .DEPTH (`SBWM_FIFO_DEPTH)
    ) u_fifo (
        .mclk (mclk),
        .rstn (rstn),
        .push (wr_in),
        .pop  (wr_out)
    );

    // memory array, one port: a read fetch takes it and stalls drain
    logic [`SBWM_DW-1:0] mem_r [`SBWM_DEPTH];
    wire  [`SBWM_DW-1:0] merged;
    wire  [`SBWM_DW-1:0] old_word;
    wire                 rd_fetch;
    wire                 drain_fire;

    assign old_word     = mem_r[wr_out.entry.addr];
    assign wr_out.ready = !rd_fetch;
    assign drain_fire   = wr_out.valid && !rd_fetch;

    sbwm_lane_merge u_merge (
        .mode     (mode_r),
        .sel_n    (wr_out.entry.sel_n),
        .old_word (old_word),
        .new_word (wr_out.entry.data),
        .merged   (merged)
    );

    always_ff @(posedge mclk) begin
        if (drain_fire) mem_r[wr_out.entry.addr] <= merged;
    end

    // read port
    sbwm_rstate_t        r_state_r;
    logic [`SBWM_AW-1:0] raddr_r;
    wire                 rd_start;
    wire [`SBWM_AW-1:0]  fetch_addr;

    assign rd_start   = (r_state_r == R_IDLE) && kt_rise && !s_rps_n;
    assign rd_fetch   = ((r_state_r == R_ARM) && oref_c_rise) ||
                        ((r_state_r == R_FIRST) && oref_t_rise);
    assign fetch_addr = (r_state_r == R_ARM) ? raddr_r
                                             : raddr_r + `SBWM_AW'(1);

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            r_state_r <= R_IDLE;
            raddr_r   <= '0;
        end else begin
            case (r_state_r)
                R_IDLE: if (rd_start) begin
                    r_state_r <= R_ARM;
                    raddr_r   <= s_raddr;
                end
                R_ARM:   if (oref_c_rise) r_state_r <= R_FIRST;
                R_FIRST: if (oref_t_rise) r_state_r <= R_LAST;
                R_LAST:  if (oref_t_rise || oref_c_rise)
                    r_state_r <= R_IDLE;
                default: r_state_r <= R_IDLE;
            endcase
        end
    end

    // outputs stay off until a read launches them
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            read_output_bus <= '0;
            read_output_oe  <= 1'b0;
        end else if (rd_fetch) begin
            read_output_bus <= mem_r[fetch_addr];
            read_output_oe  <= 1'b1;
        end else if (r_state_r == R_LAST &&
                     (oref_t_rise || oref_c_rise)) begin
            read_output_oe  <= 1'b0;
        end
    end

    // checks
    sequence s_wr_begin;
        wr_start ##1 (w_state_r == W_SECOND);
    endsequence

    sequence s_wr_close;
        wr_second && !pend_busy ##1 pend0_v_r && pend1_v_r;
    endsequence

    a_start_capture: assert property (@(posedge mclk) disable iff (!rstn)
        wr_start |=> (w_state_r == W_SECOND) && word0_r == $past(s_data))
        else $error("write start not captured");

    a_burst_addr_seq: assert property (@(posedge mclk) disable iff (!rstn)
        s_wr_begin ##[1:1000] s_wr_close |->
        pend1_r.addr == pend0_r.addr + `SBWM_AW'(1))
        else $error("second word not at address plus one");

    a_sel_per_word: assert property (@(posedge mclk) disable iff (!rstn)
        (wr_second && !pend_busy) |=>
        pend1_r.sel_n == $past(s_sel_n) &&
        pend0_r.sel_n == $past(sel0_r))
        else $error("selects not kept per word");

    a_idle_ignore: assert property (@(posedge mclk) disable iff (!rstn)
        (w_state_r == W_IDLE) && !wr_start |=>
        $stable(word0_r) && $stable(sel0_r))
        else $error("selects taken outside a write");

    a_full_write: assert property (@(posedge mclk) disable iff (!rstn)
        drain_fire && wr_out.entry.sel_n == 4'h0 && mode_r != SBWM_X8
        && mode_r != SBWM_X9 && mode_r != SBWM_X18 |=>
        mem_r[$past(wr_out.entry.addr)] == $past(wr_out.entry.data))
        else $error("full word not written");

    a_no_write: assert property (@(posedge mclk) disable iff (!rstn)
        drain_fire && wr_out.entry.sel_n == 4'hF |=>
        mem_r[$past(wr_out.entry.addr)] == $past(old_word))
        else $error("masked word changed memory");

    a_low_lane: assert property (@(posedge mclk) disable iff (!rstn)
        drain_fire && mode_r == SBWM_X18 &&
        wr_out.entry.sel_n[1:0] == 2'h2 |->
        merged[`SBWM_LANE0] == wr_out.entry.data[`SBWM_LANE0] &&
        merged[`SBWM_LANE1] == old_word[`SBWM_LANE1])
        else $error("low lane merge wrong");

    a_high_nibble: assert property (@(posedge mclk) disable iff (!rstn)
        drain_fire && mode_r == SBWM_X8 &&
        wr_out.entry.sel_n[1:0] == 2'h1 |->
        merged[`SBWM_NIB_HI] == wr_out.entry.data[`SBWM_NIB_HI] &&
        merged[`SBWM_NIB_LO] == old_word[`SBWM_NIB_LO])
        else $error("high lane merge wrong");

    a_x9_lane: assert property (@(posedge mclk) disable iff (!rstn)
        drain_fire && mode_r == SBWM_X9 |->
        merged[`SBWM_LANE0] == (wr_out.entry.sel_n[0] ?
        old_word[`SBWM_LANE0] : wr_out.entry.data[`SBWM_LANE0]))
        else $error("single lane merge wrong");

    a_x36_lane2: assert property (@(posedge mclk) disable iff (!rstn)
        drain_fire && mode_r == SBWM_X36 &&
        wr_out.entry.sel_n == 4'hB |->
        merged[`SBWM_LANE2] == wr_out.entry.data[`SBWM_LANE2] &&
        merged[`SBWM_LANE3] == old_word[`SBWM_LANE3] &&
        merged[17:0] == old_word[17:0])
        else $error("lane two merge wrong");

    a_read_launch: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(read_output_oe) |-> $past(oref_c_rise))
        else $error("read data not on output edge");

    a_quiet_idle: assert property (@(posedge mclk) disable iff (!rstn)
        (r_state_r == R_IDLE) && !$past(rd_fetch) |-> !read_output_oe)
        else $error("outputs driven with no read");
endmodule // sbwm_write_mask

// File: design/sbwm_defines.svh
// constants for the write lane masking block
`ifndef SBWM_DEFINES_SVH
`define SBWM_DEFINES_SVH

// word and array geometry
`define SBWM_DW          36
`define SBWM_SELW        4
`define SBWM_AW          4
`define SBWM_DEPTH       16
// write fifo
`define SBWM_FIFO_DEPTH  8
// lane positions
`define SBWM_NIB_W       4
`define SBWM_NIB_LO      3:0
`define SBWM_NIB_HI      7:4
`define SBWM_LANE_W      9
`define SBWM_LANE0       8:0
`define SBWM_LANE1       17:9
`define SBWM_LANE2       26:18
`define SBWM_LANE3       35:27
// strap capture waits for the synchroniser to fill
`define SBWM_STRAP_WAIT  2'h2
// pin count through the input synchroniser
`define SBWM_PIN_W       56

`endif

// File: design/sbwm_pkg.sv
// types shared by the write lane masking block
package sbwm_pkg;
    `include "sbwm_defines.svh"

    typedef enum logic [1:0] {
        SBWM_X8,
        SBWM_X9,
        SBWM_X18,
        SBWM_X36
    } sbwm_width_t;

    typedef struct packed {
        logic [`SBWM_AW-1:0]   addr;
        logic [`SBWM_DW-1:0]   data;
        logic [`SBWM_SELW-1:0] sel_n;
    } sbwm_entry_t;

    typedef enum logic [0:0] {W_IDLE, W_SECOND} sbwm_wstate_t;
    typedef enum logic [1:0] {R_IDLE, R_ARM, R_FIRST, R_LAST} sbwm_rstate_t;
endpackage

// File: design/sbwm_stream_if.sv
// valid/ready stream of write entries between block modules
`timescale 1ns/1ps
interface sbwm_stream_if;
    import sbwm_pkg::*;
    sbwm_entry_t entry;
    logic        valid;
    logic        ready;
    modport src (output entry, output valid, input ready);
    modport snk (input entry, input valid, output ready);
endinterface

// File: design/sbwm_fifo.sv
// parameterised fifo holding write entries
`timescale 1ns/1ps
module sbwm_fifo #(
    parameter int WIDTH = $bits(sbwm_pkg::sbwm_entry_t),
    parameter int DEPTH = 8
) (
    input  wire logic   mclk,
    input  wire logic   rstn,
    sbwm_stream_if.snk  push,
    sbwm_stream_if.src  pop
);
    import sbwm_pkg::*;
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store_r [DEPTH];
    logic [PW:0]      wr_ptr_r;
    logic [PW:0]      rd_ptr_r;
    wire              full;
    wire              empty;
    wire              push_fire;
    wire              pop_fire;

    assign full      = (wr_ptr_r[PW] != rd_ptr_r[PW]) &&
                       (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]);
    assign empty     = (wr_ptr_r == rd_ptr_r);
    assign push.ready = !full;
    assign pop.valid = !empty;
    assign pop.entry = sbwm_entry_t'(store_r[rd_ptr_r[PW-1:0]]);
    assign push_fire = push.valid && !full;
    assign pop_fire  = pop.ready && !empty;

    always_ff @(posedge mclk) begin
        if (push_fire) begin
            store_r[wr_ptr_r[PW-1:0]] <= WIDTH'(push.entry);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push_fire) wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop_fire)  rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end
endmodule // sbwm_fifo

// File: design/sbwm_lane_merge.sv
// merges new write data into the stored word under the lane selects
`timescale 1ns/1ps
`include "sbwm_defines.svh"
module sbwm_lane_merge (
    input  wire sbwm_pkg::sbwm_width_t   mode,
    input  wire logic [`SBWM_SELW-1:0]   sel_n,
    input  wire logic [`SBWM_DW-1:0]     old_word,
    input  wire logic [`SBWM_DW-1:0]     new_word,
    output logic [`SBWM_DW-1:0]          merged
);
    import sbwm_pkg::*;

    function automatic logic [`SBWM_DW-1:0] lane_mask(
        input sbwm_width_t           m,
        input logic [`SBWM_SELW-1:0] s
    );
        logic [`SBWM_DW-1:0] k;
        k = '0;
        case (m)
            SBWM_X8: begin
                k[`SBWM_NIB_LO] = {`SBWM_NIB_W{!s[0]}};
                k[`SBWM_NIB_HI] = {`SBWM_NIB_W{!s[1]}};
            end
            SBWM_X9: k[`SBWM_LANE0] = {`SBWM_LANE_W{!s[0]}};
            SBWM_X18: begin
                k[`SBWM_LANE0] = {`SBWM_LANE_W{!s[0]}};
                k[`SBWM_LANE1] = {`SBWM_LANE_W{!s[1]}};
            end
            default: begin
                k[`SBWM_LANE0] = {`SBWM_LANE_W{!s[0]}};
                k[`SBWM_LANE1] = {`SBWM_LANE_W{!s[1]}};
                k[`SBWM_LANE2] = {`SBWM_LANE_W{!s[2]}};
                k[`SBWM_LANE3] = {`SBWM_LANE_W{!s[3]}};
            end
        endcase
        return k;
    endfunction

    wire [`SBWM_DW-1:0] mask;

    // unselected lanes keep the stored bits
    assign mask   = lane_mask(mode, sel_n);
    assign merged = (new_word & mask) | (old_word & ~mask);
endmodule // sbwm_lane_merge

// File: bench/sbwm_ctrl_model.sv
// memory controller model driving the write and read ports
`timescale 1ns/1ps
module sbwm_ctrl_model #(
    parameter int PH = 6
) (
    input  wire logic        mclk,
    output logic             in_edge_ref_true,
    output logic             in_edge_ref_comp,
    output logic             output_timing_true,
    output logic             output_timing_comp,
    output logic             write_port_sel_n,
    output logic             read_port_sel_n,
    output logic [3:0]       byte_lane_write_select_n,
    output logic [35:0]      write_input_bus,
    output logic [3:0]       write_addr,
    output logic [3:0]       read_addr,
    input  wire logic [35:0] read_output_bus,
    input  wire logic        read_output_oe
);
    import sbwm_pkg::*;

    // output pair not both high, so the strap sees two-clock mode
    initial begin
        in_edge_ref_true = 1'b1;
        in_edge_ref_comp = 1'b1;
        output_timing_true = 1'b0;
        output_timing_comp = 1'b1;
        write_port_sel_n = 1'b1;
        read_port_sel_n = 1'b1;
        byte_lane_write_select_n = 4'hF;
        write_input_bus = 36'h0;
        write_addr = 4'h0;
        read_addr = 4'h0;
    end

    // phase of several mclk covers synchroniser and hold
    task automatic ph();
        repeat (PH) @(negedge mclk);
    endtask

    task automatic write_burst(input logic [3:0] a, input logic [35:0] d0,
                               input logic [35:0] d1, input logic [3:0] s0,
                               input logic [3:0] s1);
        write_port_sel_n = 1'b0;
        write_input_bus = d0;
        byte_lane_write_select_n = s0;
        write_addr = a;
        in_edge_ref_true = 1'b0;
        ph();
        in_edge_ref_true = 1'b1;
        in_edge_ref_comp = 1'b0;
        ph();
        write_port_sel_n = 1'b1;
        write_input_bus = d1;
        byte_lane_write_select_n = s1;
        ph();
        in_edge_ref_true = 1'b0;
        in_edge_ref_comp = 1'b1;
        ph();
        // stale bus inverted, live selects with no burst open
        write_input_bus = ~d1;
        byte_lane_write_select_n = 4'h0;
        write_addr = ~a;
        ph();
        in_edge_ref_true = 1'b1;
        ph();
    endtask

    // both output clocks high through reset straps single clock mode
    task automatic park_out(input logic v);
        output_timing_true = v;
    endtask

    // single clock mode: the input pair also times the read data
    task automatic read_single(input logic [3:0] a, output logic [35:0] q0,
                               output logic [35:0] q1, output logic oe2);
        read_port_sel_n = 1'b0;
        read_addr = a;
        in_edge_ref_true = 1'b0;
        ph();
        in_edge_ref_true = 1'b1;
        in_edge_ref_comp = 1'b0;
        ph();
        read_port_sel_n = 1'b1;
        read_addr = ~a;
        ph();
        in_edge_ref_true = 1'b0;
        in_edge_ref_comp = 1'b1;
        ph();
        q0 = read_output_bus;
        in_edge_ref_true = 1'b1;
        ph();
        q1 = read_output_bus;
        in_edge_ref_comp = 1'b0;
        ph();
        in_edge_ref_comp = 1'b1;
        ph();
        oe2 = read_output_oe;
    endtask

    task automatic read_burst(input logic [3:0] a, output logic [35:0] q0,
                              output logic [35:0] q1, output logic oe0,
                              output logic oe1, output logic oe2);
        read_port_sel_n = 1'b0;
        read_addr = a;
        in_edge_ref_true = 1'b0;
        ph();
        in_edge_ref_true = 1'b1;
        in_edge_ref_comp = 1'b0;
        ph();
        read_port_sel_n = 1'b1;
        read_addr = ~a;
        ph();
        in_edge_ref_true = 1'b0;
        in_edge_ref_comp = 1'b1;
        ph();
        in_edge_ref_true = 1'b1;
        output_timing_comp = 1'b0;
        ph();
        output_timing_comp = 1'b1;
        ph();
        q0 = read_output_bus;
        oe0 = read_output_oe;
        output_timing_true = 1'b1;
        ph();
        q1 = read_output_bus;
        oe1 = read_output_oe;
        output_timing_true = 1'b0;
        output_timing_comp = 1'b0;
        ph();
        output_timing_comp = 1'b1;
        ph();
        oe2 = read_output_oe;
    endtask
endmodule // sbwm_ctrl_model

// File: bench/tb_sram_byte_write_mask.sv
// self-checking bench for the write lane masking block
`timescale 1ns/1ps
`define CHK_EQ(got, exp) \
    begin \
        checked++; \
        if ((got) !== (exp)) begin \
            n_fail++; \
            $display("BAD t=%0t got %h exp %h", $time, got, exp); \
        end \
    end
module tb_sram_byte_write_mask;
    import sbwm_pkg::*;
    logic        mclk, rstn, ket, kec, ot, oc, wsel_n, rsel_n, oe, stall;
    logic [1:0]  width_strap;
    logic [3:0]  sel_n, waddr, raddr;
    logic [35:0] wbus, rbus;
    logic [35:0] mem_m [16];
    sbwm_width_t cur;
    int          n_fail = 0;
    int          checked = 0;

    sbwm_write_mask dut (.mclk(mclk), .rstn(rstn), .width_strap(width_strap),
        .in_edge_ref_true(ket), .in_edge_ref_comp(kec),
        .output_timing_true(ot), .output_timing_comp(oc),
        .write_port_sel_n(wsel_n), .read_port_sel_n(rsel_n),
        .byte_lane_write_select_n(sel_n), .write_input_bus(wbus),
        .write_addr(waddr), .read_addr(raddr), .read_output_bus(rbus),
        .read_output_oe(oe), .write_stall(stall));
    sbwm_ctrl_model ctl (.mclk(mclk), .in_edge_ref_true(ket),
        .in_edge_ref_comp(kec), .output_timing_true(ot),
        .output_timing_comp(oc), .write_port_sel_n(wsel_n),
        .read_port_sel_n(rsel_n), .byte_lane_write_select_n(sel_n),
        .write_input_bus(wbus), .write_addr(waddr), .read_addr(raddr),
        .read_output_bus(rbus), .read_output_oe(oe));

    always #2.5 mclk = ~mclk;

    function automatic logic [35:0] lmask(input sbwm_width_t m,
                                          input logic [3:0] s);
        logic [35:0] r;
        r = 36'h0;
        case (m)
            SBWM_X8: r[7:0] = {{4{~s[1]}}, {4{~s[0]}}};
            SBWM_X9: r[8:0] = {9{~s[0]}};
            SBWM_X18: r[17:0] = {{9{~s[1]}}, {9{~s[0]}}};
            default: r = {{9{~s[3]}}, {9{~s[2]}}, {9{~s[1]}}, {9{~s[0]}}};
        endcase
        return r;
    endfunction

    function automatic logic [35:0] wmask(input sbwm_width_t m);
        case (m)
            SBWM_X8: return 36'hFF;
            SBWM_X9: return 36'h1FF;
            SBWM_X18: return 36'h3FFFF;
            default: return 36'hFFFFFFFFF;
        endcase
    endfunction

    task automatic complete_run();
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [35:0] d0,
                      input logic [35:0] d1, input logic [3:0] s0,
                      input logic [3:0] s1);
        logic [3:0]  a1;
        logic [35:0] m0, m1;
        a1 = a + 4'h1;
        m0 = lmask(cur, s0);
        m1 = lmask(cur, s1);
        ctl.write_burst(a, d0, d1, s0, s1);
        mem_m[a] = (mem_m[a] & ~m0) | (d0 & m0);
        mem_m[a1] = (mem_m[a1] & ~m1) | (d1 & m1);
        `CHK_EQ(stall, 1'b0)
    endtask

    task automatic rd_chk(input logic [3:0] a);
        logic [3:0]  a1;
        logic [35:0] q0, q1, wm;
        logic        oe0, oe1, oe2;
        a1 = a + 4'h1;
        wm = wmask(cur);
        ctl.read_burst(a, q0, q1, oe0, oe1, oe2);
        `CHK_EQ(oe0, 1'b1)
        `CHK_EQ(oe1, 1'b1)
        `CHK_EQ(q0 & wm, mem_m[a] & wm)
        `CHK_EQ(q1 & wm, mem_m[a1] & wm)
        `CHK_EQ(oe2, 1'b0)
    endtask

    // reset with a new width strap; outputs stay quiet
    task automatic do_reset(input sbwm_width_t m);
        @(negedge mclk);
        rstn = 1'b0;
        width_strap = m;
        repeat (3) begin
            @(negedge mclk);
            `CHK_EQ(oe, 1'b0)
            `CHK_EQ(rbus, 36'h0)
        end
        rstn = 1'b1;
        repeat (8) @(negedge mclk);
        `CHK_EQ(oe, 1'b0)
        cur = m;
    endtask

    task automatic sc_full();
        for (int k = 0; k < 8; k++) begin
            wr(4'(2 * k), 36'hC3A5960F0 ^ {9{4'(k)}},
               36'h35C69F0A5 ^ {9{4'(k)}}, 4'h0, 4'h0);
        end
        for (int k = 0; k < 8; k++) begin
            rd_chk(4'(2 * k));
        end
    endtask

    // every select value once, word1 gets the complement of word0
    task automatic sc_masks();
        for (int k = 0; k < 8; k++) begin
            wr(4'(2 * k), 36'h987654321 ^ {9{4'(k)}},
               36'h6789ABCDE ^ {9{4'(k)}}, 4'(k), 4'(15 - k));
        end
        for (int k = 0; k < 8; k++) begin
            rd_chk(4'(2 * k));
        end
    endtask

    task automatic sc_wrap();
        wr(4'hF, 36'h1E2D3C4B5, 36'hA0B1C2D3E, 4'h0, 4'h0);
        rd_chk(4'hF);
    endtask

    // output pair parked high at strap time selects single clock mode
    task automatic sc_single();
        logic [35:0] q0, q1;
        logic        oe2;
        ctl.park_out(1'b1);
        do_reset(SBWM_X36);
        wr(4'h6, 36'h5A5A5A5A5, 36'hA5A5A5A5A, 4'h0, 4'h0);
        ctl.read_single(4'h6, q0, q1, oe2);
        `CHK_EQ(q0, mem_m[4'h6])
        `CHK_EQ(q1, mem_m[4'h7])
        `CHK_EQ(oe2, 1'b0)
    endtask

    initial begin
        mclk = 1'b0;
        rstn = 1'b0;
        width_strap = 2'h0;
        cur = SBWM_X8;
        for (int i = 0; i < 4; i++) begin
            do_reset(sbwm_width_t'(i));
            sc_full();
            sc_masks();
            sc_wrap();
        end
        sc_single();
        complete_run();
    end

    // about 6200 mclk expected; allow several times that
    initial begin
        #200000;
        n_fail++;
        complete_run();
    end
endmodule // tb_sram_byte_write_mask
